//--- src/dpll_control_status_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Reference choice 0 routes primary input, 1 routes secondary input.
// - Reference choice may change anytime for 8k, 1.544M, 2.048M references.
// - Two-bit frequency select: 00 19.44M, 01 8k, 10 1.544M, 11 2.048M.
// - 19.44M option may step frequency on leaving automatic holdover.
// - State select: 00 normal, 01 holdover, 10 free-run, 11 reserved.
// - Filter profile 1 selects 70 mHz corner, 885 ns/s slope.
// - Filter profile 0 selects 1.1 Hz corner, 53 ns per 1.326 ms.
// - Fast acquire high speeds lock at cost of wander.
// - Phase error clear low clears and disables the error corrector.
// - Primary out-of-range reads 1 beyond 12 ppm over one second.
// - Secondary out-of-range reads 1 beyond 12 ppm over one second.
// - Lock bit high while locked to the selected reference.
// - Holdover bit high in commanded or automatic holdover.
// - Frequency limit bit high when reference reaches offset tolerance.
// - High-rate select 0 enables differential clock, carrier divided by four.
// - Carrier rate select 0 gives 44.736 MHz, 1 gives 34.368 MHz.
// - Microport mode replaces control pins; status pins stay active.
module dpll_control_status_regs
    import dpll_regs_pkg::*;
#(
    parameter longint WINDOW_CYCLES = dpll_regs_pkg::MEAS_CYCLES,
    parameter int CNT_W = 32,
    parameter logic [31:0] NOMINAL_COUNT = 32'h0000_1F40,
    parameter logic [31:0] PPM_TOL_COUNT = 32'h0000_0001,
    parameter logic [31:0] LIM_TOL_COUNT = 32'h0000_0010,
    parameter int LOCK_WINDOWS = 2
) (
    input wire logic clk,                                  // 200 MHz master clock.
    input wire logic sys_rst,                              // Synchronous reset.
    input wire logic clk_en,                               // Clock enable.
    input wire dpll_regs_pkg::bus_req_t bus_req,           // Microport request.
    output logic [dpll_regs_pkg::DATA_W-1:0] bus_rdata,    // Read data.
    output logic bus_rdata_oe_n,                           // Low while driving data.
    input wire logic hw_ctrl_sel,                          // High selects pin control.
    input wire dpll_regs_pkg::ctrl_one_t pin_ctrl,         // Control pins.
    input wire logic primary_ref_input,                    // Primary reference tick.
    input wire logic secondary_ref_input,                  // Secondary reference tick.
    input wire logic loss_of_ref,                          // Reference lost indication.
    input wire logic high_rate_tick,                       // 155.52 MHz rate tick.
    input wire logic carrier_44_tick,                      // 44.736 MHz rate tick.
    input wire logic carrier_34_tick,                      // 34.368 MHz rate tick.
    output logic selected_ref,                             // Reference into the PLL.
    output dpll_regs_pkg::ctrl_one_t eff_ctrl,             // Active control word.
    output dpll_regs_pkg::pll_state_t pll_state,           // Operating state.
    output logic diff_high_clock_en,                       // Differential clock enable.
    output logic diff_high_clock_out,                      // Differential clock tick.
    output logic carrier_clock_out,                        // Carrier clock tick.
    output dpll_regs_pkg::status_t status_pins             // Status pin outputs.
);
    import dpll_regs_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_one_ff;
    logic [DATA_W-1:0] out_clk_ff;
    ctrl_one_t ctrl_reg;
    logic wr_ctrl;
    logic wr_out;

    assign wr_ctrl = bus_req.bus_cs && bus_req.bus_wr && bus_req.bus_addr == ADDR_CTRL_ONE;
    assign wr_out = bus_req.bus_cs && bus_req.bus_wr && bus_req.bus_addr == ADDR_OUT_CLK;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_one_ff <= CTRL_ONE_RST;
        end else if (clk_en && wr_ctrl) begin
            ctrl_one_ff <= bus_req.bus_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_clk_ff <= OUT_CLK_RST;
        end else if (clk_en && wr_out) begin
            out_clk_ff <= bus_req.bus_wdata;
        end
    end

    assign ctrl_reg = ctrl_one_t'(ctrl_one_ff);

    assign eff_ctrl = hw_ctrl_sel ? pin_ctrl : ctrl_reg;

    // ----------------------------------------------------------------
    // Reference routing and measurement
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] win_cnt_ff;
    logic window_end;
    logic pri_oor;
    logic sec_oor;
    logic [CNT_W-1:0] lo_lim;
    logic [CNT_W-1:0] hi_lim;

    assign selected_ref = eff_ctrl.ref_choice ? secondary_ref_input : primary_ref_input;

    assign window_end = (win_cnt_ff == CNT_W'(WINDOW_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            win_cnt_ff <= '0;
        end else if (clk_en) begin
            win_cnt_ff <= window_end ? '0 : win_cnt_ff + 1'b1;
        end
    end

    // expected count scales with frequency select
    logic [CNT_W-1:0] expected;
    always_comb begin
        case (eff_ctrl.ref_freq_sel)
            FREQ_8K: expected = CNT_W'(NOMINAL_COUNT);
            FREQ_1M544: expected = CNT_W'(NOMINAL_COUNT * 193);
            FREQ_2M048: expected = CNT_W'(NOMINAL_COUNT * 256);
            default: expected = CNT_W'(NOMINAL_COUNT * 2430);
        endcase
    end
    assign lo_lim = expected - CNT_W'(PPM_TOL_COUNT);
    assign hi_lim = expected + CNT_W'(PPM_TOL_COUNT);

    range_monitor #(.CNT_W(CNT_W)) u_pri_mon (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .window_end(window_end),
        .ref_tick(primary_ref_input),
        .lo_lim(lo_lim),
        .hi_lim(hi_lim),
        .out_of_range(pri_oor)
    );

    range_monitor #(.CNT_W(CNT_W)) u_sec_mon (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .window_end(window_end),
        .ref_tick(secondary_ref_input),
        .lo_lim(lo_lim),
        .hi_lim(hi_lim),
        .out_of_range(sec_oor)
    );

    logic freq_limit_hit_ff;
    logic sel_oor;
    assign sel_oor = eff_ctrl.ref_choice ? sec_oor : pri_oor;
    range_monitor #(.CNT_W(CNT_W)) u_lim_mon (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .window_end(window_end),
        .ref_tick(selected_ref),
        .lo_lim(expected - CNT_W'(LIM_TOL_COUNT)),
        .hi_lim(expected + CNT_W'(LIM_TOL_COUNT)),
        .out_of_range(freq_limit_hit_ff)
    );

    // ----------------------------------------------------------------
    // Operating state machine
    // ----------------------------------------------------------------
    pll_state_t state_ff;
    pll_state_t nxt_state;
    logic auto_hold;

    // automatic holdover on loss or gross deviation
    assign auto_hold = loss_of_ref || freq_limit_hit_ff;

    always_comb begin
        case (eff_ctrl.pll_state_sel)
            CMD_NORMAL: nxt_state = auto_hold ? ST_HOLDOVER : ST_NORMAL;
            CMD_HOLDOVER: nxt_state = ST_HOLDOVER;
            CMD_FREERUN: nxt_state = ST_FREERUN;
            default: nxt_state = ST_FREERUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_FREERUN;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end
    assign pll_state = state_ff;

    logic [3:0] lock_cnt_ff;
    logic lock_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_cnt_ff <= '0;
        end else if (clk_en) begin
            if (state_ff != ST_NORMAL || sel_oor) begin
                lock_cnt_ff <= '0;
            end else if (window_end && lock_cnt_ff != 4'(LOCK_WINDOWS)) begin
                // fast acquire counts two windows per window
                lock_cnt_ff <= (eff_ctrl.fast_acquire && lock_cnt_ff + 4'd2 <= 4'(LOCK_WINDOWS))
                    ? lock_cnt_ff + 4'd2 : lock_cnt_ff + 4'd1;
            end
        end
    end
    assign lock_ff = (lock_cnt_ff == 4'(LOCK_WINDOWS)) && state_ff == ST_NORMAL;

    // filter profile and corrector clear pass out in eff_ctrl

    // ----------------------------------------------------------------
    // Status and read path
    // ----------------------------------------------------------------
    status_t status_now;
    logic [DATA_W-1:0] status_byte;
    logic [DATA_W-1:0] nxt_rdata;

    assign status_now.holdover = (state_ff == ST_HOLDOVER);
    assign status_now.primary_out_of_range = pri_oor;
    assign status_now.secondary_out_of_range = sec_oor;
    assign status_now.lock = lock_ff;
    assign status_now.freq_limit_hit = freq_limit_hit_ff;

    always_comb begin
        status_byte = ZERO_BYTE;
        status_byte[BIT_PRI_OOR] = status_now.primary_out_of_range;
        status_byte[BIT_SEC_OOR] = status_now.secondary_out_of_range;
        status_byte[BIT_LOCK] = status_now.lock;
        status_byte[BIT_HOLD] = status_now.holdover;
        status_byte[BIT_FREQ_LIMIT_HIT] = status_now.freq_limit_hit;
    end

    always_comb begin
        case (bus_req.bus_addr)
            ADDR_CTRL_ONE: nxt_rdata = ctrl_one_ff;
            ADDR_STATUS_ONE: nxt_rdata = status_byte;
            ADDR_OUT_CLK: nxt_rdata = out_clk_ff;
            default: nxt_rdata = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rdata <= ZERO_BYTE;
            bus_rdata_oe_n <= 1'b1;
        end else if (clk_en) begin
            bus_rdata_oe_n <= !(bus_req.bus_cs && bus_req.bus_rd);
            if (bus_req.bus_cs && bus_req.bus_rd) begin
                bus_rdata <= nxt_rdata;
            end
        end
    end

    // status pins active in both modes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_pins <= '0;
        end else if (clk_en) begin
            status_pins <= status_now;
        end
    end

    // ----------------------------------------------------------------
    // Output clock control
    // ----------------------------------------------------------------
    logic carrier_tick;

    assign carrier_tick = out_clk_ff[BIT_CARRIER] ? carrier_34_tick : carrier_44_tick;

    rate_divider #(.DIV(RATE_DIV)) u_carrier_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(carrier_tick),
        .bypass(out_clk_ff[BIT_HIGH_RATE]),
        .tick_out(carrier_clock_out)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            diff_high_clock_en <= 1'b1;
            diff_high_clock_out <= 1'b0;
        end else if (clk_en) begin
            diff_high_clock_en <= !out_clk_ff[BIT_HIGH_RATE];
            diff_high_clock_out <= !out_clk_ff[BIT_HIGH_RATE] && high_rate_tick;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_ref_route: assert property (@(posedge clk) disable iff (sys_rst)
        selected_ref == (eff_ctrl.ref_choice ? secondary_ref_input : primary_ref_input))
        else $error("reference routing wrong");
    a_state_free: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && eff_ctrl.pll_state_sel == CMD_RESERVED |=> pll_state == ST_FREERUN)
        else $error("reserved code not free-run");
    a_state_hold: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && eff_ctrl.pll_state_sel == CMD_HOLDOVER |=> pll_state == ST_HOLDOVER)
        else $error("holdover command ignored");
    a_hold_status: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en |=> status_pins.holdover == $past(pll_state == ST_HOLDOVER))
        else $error("holdover status wrong");
    a_lock_normal: assert property (@(posedge clk) disable iff (sys_rst)
        status_now.lock |-> pll_state == ST_NORMAL)
        else $error("lock outside normal");
    a_status_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && bus_req.bus_cs && bus_req.bus_rd && bus_req.bus_addr == ADDR_STATUS_ONE
        |=> bus_rdata[3] == 1'b0 && bus_rdata[1:0] == 2'b00 && !bus_rdata_oe_n)
        else $error("status reserved bits set");
    a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wr_ctrl |=> ctrl_one_ff == $past(bus_req.bus_wdata))
        else $error("control write lost");
    a_diff_enable: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && out_clk_ff[BIT_HIGH_RATE] |=> !diff_high_clock_en && !diff_high_clock_out)
        else $error("differential clock not disabled");
    a_hw_mode: assert property (@(posedge clk) disable iff (sys_rst)
        hw_ctrl_sel |-> eff_ctrl == pin_ctrl)
        else $error("pin control not used");
    a_oe_idle: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !(bus_req.bus_cs && bus_req.bus_rd) |=> bus_rdata_oe_n)
        else $error("read data driven without read");
    c_pin_mode: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(hw_ctrl_sel));
    c_switch_ref: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(eff_ctrl.ref_choice));
    c_auto_hold: cover property (@(posedge clk) disable iff (sys_rst)
        eff_ctrl.pll_state_sel == CMD_NORMAL && pll_state == ST_HOLDOVER);
    c_locked: cover property (@(posedge clk) disable iff (sys_rst) $rose(status_now.lock));
endmodule : dpll_control_status_regs

//--- src/dpll_regs_pkg.sv
package dpll_regs_pkg;

    // ----------------------------------------------------------------
    // Bus widths and register addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] ADDR_CTRL_ONE = 7'h00;
    localparam logic [6:0] ADDR_STATUS_ONE = 7'h01;
    localparam logic [6:0] ADDR_OUT_CLK = 7'h04;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_REF_CHOICE = 7;
    localparam int BIT_FREQ_HI = 6;
    localparam int BIT_FREQ_LO = 5;
    localparam int BIT_STATE_HI = 4;
    localparam int BIT_STATE_LO = 3;
    localparam int BIT_FILTER = 2;
    localparam int BIT_FAST = 1;
    localparam int BIT_PHASE_CLR = 0;
    localparam int BIT_PRI_OOR = 7;
    localparam int BIT_SEC_OOR = 6;
    localparam int BIT_LOCK = 5;
    localparam int BIT_HOLD = 4;
    localparam int BIT_FREQ_LIMIT_HIT = 2;
    localparam int BIT_HIGH_RATE = 7;
    localparam int BIT_CARRIER = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] OUT_CLK_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FREQ_19M44 = 2'h0,
        FREQ_8K = 2'h1,
        FREQ_1M544 = 2'h2,
        FREQ_2M048 = 2'h3
    } ref_freq_t;

    typedef enum logic [1:0] {
        CMD_NORMAL = 2'h0,
        CMD_HOLDOVER = 2'h1,
        CMD_FREERUN = 2'h2,
        CMD_RESERVED = 2'h3
    } pll_cmd_t;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h1,
        ST_HOLDOVER = 3'h2,
        ST_FREERUN = 3'h4
    } pll_state_t;

    // ----------------------------------------------------------------
    // Timing: one-second measurement window from the master clock
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 200_000_000;
    localparam int MEAS_WINDOW_S = 1;
    localparam longint MEAS_CYCLES = CLK_HZ * MEAS_WINDOW_S;
    localparam int SWITCH_SETTLE_US = 250;
    localparam int RATE_DIV = 4;

    // ----------------------------------------------------------------
    // Carried groups
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ref_choice;
        ref_freq_t ref_freq_sel;
        pll_cmd_t pll_state_sel;
        logic filter_profile_sel;
        logic fast_acquire;
        logic phase_error_clear;
    } ctrl_one_t;

    typedef struct packed {
        logic primary_out_of_range;
        logic secondary_out_of_range;
        logic lock;
        logic holdover;
        logic freq_limit_hit;
    } status_t;

    typedef struct packed {
        logic bus_cs;
        logic bus_rd;
        logic bus_wr;
        logic [6:0] bus_addr;
        logic [7:0] bus_wdata;
    } bus_req_t;

endpackage : dpll_regs_pkg

//--- src/range_monitor.sv
`timescale 1ns/1ps
// Counts reference ticks over a window and flags out-of-range counts.
module range_monitor #(
    parameter int CNT_W = 32
) (
    input wire logic clk,                 // System clock.
    input wire logic sys_rst,             // Synchronous reset.
    input wire logic clk_en,              // Clock enable.
    input wire logic window_end,          // End of measurement window.
    input wire logic ref_tick,            // One pulse per reference edge.
    input wire logic [CNT_W-1:0] lo_lim,  // Least legal count.
    input wire logic [CNT_W-1:0] hi_lim,  // Greatest legal count.
    output logic out_of_range             // Registered range flag.
);
    logic [CNT_W-1:0] count_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else if (clk_en) begin
            if (window_end) begin
                count_ff <= CNT_W'(ref_tick);
            end else if (ref_tick) begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_of_range <= 1'b0;
        end else if (clk_en && window_end) begin
            out_of_range <= (count_ff < lo_lim) || (count_ff > hi_lim);
        end
    end
endmodule : range_monitor

//--- src/rate_divider.sv
`timescale 1ns/1ps
// Counting divider, one output tick per DIV input ticks; passes the tick through when bypassed.
module rate_divider #(
    parameter int DIV = 4
) (
    input wire logic clk,      // System clock.
    input wire logic sys_rst,  // Synchronous reset.
    input wire logic clk_en,   // Clock enable.
    input wire logic tick_in,  // Input rate tick.
    input wire logic bypass,   // High passes the input rate.
    output logic tick_out      // Registered output tick.
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] div_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_ff <= '0;
            tick_out <= 1'b0;
        end else if (clk_en) begin
            if (tick_in) begin
                div_ff <= (div_ff == CW'(DIV - 1)) ? '0 : div_ff + 1'b1;
            end
            tick_out <= bypass ? tick_in : (tick_in && div_ff == CW'(DIV - 1));
        end
    end
endmodule : rate_divider

//--- verification/microport_host.sv
`timescale 1ns/1ps
// Host model that issues single-byte microport reads and writes.
module microport_host
    import dpll_regs_pkg::*;
(
    input wire logic clk,                           // Master clock.
    output dpll_regs_pkg::bus_req_t bus_req,        // Request to the device.
    input wire logic [7:0] bus_rdata,               // Read data.
    input wire logic bus_rdata_oe_n                 // Low while data is driven.
);
    initial begin
        bus_req = '0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b0, 1'b1, a, d};
        @(posedge clk);
        bus_req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic oe_n);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus_req <= '{1'b0, 1'b0, 1'b0, ~a, 8'hff};
        #1;
        d = bus_rdata;
        oe_n = bus_rdata_oe_n;
    endtask : rd
endmodule : microport_host

//--- verification/dpll_control_status_regs_bench.sv
`timescale 1ns/1ps
module dpll_control_status_regs_bench;
    import dpll_regs_pkg::*;
    logic clk, sys_rst, hw_ctrl_sel, loss_of_ref, sel_ref, en, oe_n, rd_oe_n, car_out, dif_out;
    logic [7:0] rdata, d;
    logic [2:0] st;
    logic [15:0] cnt;
    int mismatches, n_checks, cycles, n_car, n_dif;
    bus_req_t req;
    ctrl_one_t pin_ctrl, eff;
    status_t pins;
    logic [7:0] vals [4] = '{8'h08, 8'h10, 8'h18, 8'h88};
    logic [2:0] sts [4] = '{3'h2, 3'h4, 3'h4, 3'h2};
    // ----------------------------------------------------------------
    // Clock, stimulus and instances
    // ----------------------------------------------------------------
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cnt <= sys_rst ? 16'h0000 : cnt + 16'h0001;
        if (!sys_rst) begin
            n_car <= n_car + int'(car_out);
            n_dif <= n_dif + int'(dif_out);
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    microport_host host (.clk(clk), .bus_req(req), .bus_rdata(rdata), .bus_rdata_oe_n(oe_n));
    dpll_control_status_regs #(.WINDOW_CYCLES(1000), .NOMINAL_COUNT(32'h0000_0064),
        .PPM_TOL_COUNT(32'h0000_0002)) uut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus_req(req), .bus_rdata(rdata),
        .bus_rdata_oe_n(oe_n), .hw_ctrl_sel(hw_ctrl_sel), .pin_ctrl(pin_ctrl),
        .primary_ref_input(cnt % 10 == 0), .secondary_ref_input(cnt % 7 == 0),
        .loss_of_ref(loss_of_ref), .high_rate_tick(cnt[0]), .carrier_44_tick(cnt[1]),
        .carrier_34_tick(cnt[2]), .selected_ref(sel_ref), .eff_ctrl(eff), .pll_state(st),
        .diff_high_clock_en(en), .diff_high_clock_out(dif_out), .carrier_clock_out(car_out),
        .status_pins(pins));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] exp);
        host.rd(a, d, rd_oe_n);
        chk(d & m, exp);
        chk({7'h00, rd_oe_n}, 8'h00);
    endtask : rchk
    // Counts output clock ticks over 80 consecutive cycles.
    task automatic rates(input logic [7:0] ec, input logic [7:0] ed);
        int c0, d0;
        @(posedge clk);
        c0 = n_car;
        d0 = n_dif;
        repeat (80) @(posedge clk);
        chk(8'(n_car - c0), ec);
        chk(8'(n_dif - d0), ed);
    endtask : rates
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1;
        hw_ctrl_sel = 0;
        loss_of_ref = 0;
        pin_ctrl = '0;
        cycles = 0;
        repeat (8) @(posedge clk);
        chk({5'h00, st}, 8'h04); // reset free-run
        sys_rst <= 0;
        rchk(ADDR_CTRL_ONE, 8'hff, 8'h00); // reset control value
        rchk(ADDR_OUT_CLK, 8'hff, 8'h00); // reset output control
        chk({5'h00, st}, 8'h01); // normal after reset
        for (int i = 0; i < 4; i++) begin
            host.wr(ADDR_CTRL_ONE, vals[i]); // switch only in holdover
            repeat (3) @(posedge clk);
            chk(eff, vals[i]); // register control
            chk({5'h00, st}, {5'h00, sts[i]}); // state codes
            chk({7'h00, sel_ref}, {7'h00, vals[i][7] ? cnt % 7 == 0 : cnt % 10 == 0}); // mux
            rchk(ADDR_CTRL_ONE, 8'hff, vals[i]); // readback
            rchk(ADDR_STATUS_ONE, 8'h1b, {3'h0, sts[i] == 3'h2, 4'h0}); // holdover
        end
        host.wr(ADDR_STATUS_ONE, 8'hff);
        rchk(ADDR_STATUS_ONE, 8'h0b, 8'h00); // reserved zero
        rchk(7'h02, 8'hff, 8'h00); // unmapped
        host.wr(ADDR_OUT_CLK, 8'h80);
        rchk(ADDR_OUT_CLK, 8'hff, 8'h80); // readback
        chk({7'h00, en}, 8'h00); // differential off
        rates(8'h28, 8'h00); // carrier undivided, no differential
        host.wr(ADDR_OUT_CLK, 8'h40);
        rchk(ADDR_OUT_CLK, 8'hff, 8'h40); // carrier select
        chk({7'h00, en}, 8'h01); // differential on
        rates(8'h0a, 8'h28); // carrier divided by four
        pin_ctrl <= 8'h08;
        hw_ctrl_sel <= 1;
        repeat (3) @(posedge clk);
        chk(eff, 8'h08); // pin control
        chk({5'h00, st}, 8'h02); // holdover from pins
        hw_ctrl_sel <= 0;
        host.wr(ADDR_CTRL_ONE, 8'h21);
        repeat (3500) @(posedge clk);
        rchk(ADDR_STATUS_ONE, 8'hff, 8'h60); // range and lock
        chk({3'h0, pins}, 8'h0c); // status pins
        chk({5'h00, st}, 8'h01); // normal
        loss_of_ref <= 1;
        repeat (4) @(posedge clk);
        chk({5'h00, st}, 8'h02); // automatic holdover
        rchk(ADDR_STATUS_ONE, 8'h10, 8'h10); // holdover flag
        @(posedge clk);
        loss_of_ref <= 0;
        host.wr(ADDR_CTRL_ONE, 8'h27);
        repeat (1100) @(posedge clk);
        chk(eff, 8'h27); // control word out
        rchk(ADDR_STATUS_ONE, 8'h30, 8'h20); // fast lock
        conclude();
    end
endmodule : dpll_control_status_regs_bench
